/* ipr_router.sv */
// Summary of operation
// - Byte one routes physical sources to pin A
// - Second byte upper nibble: data sources, pin A
// - Second byte lower nibble: data sources, pin B
// - Byte three routes physical sources to pin B
// - One enables a route, zero blocks it
// - Three read-write route bytes, reset to zero
// - External source drives one pin only; pin A wins if both set
// - Ready, watermark, full are data-driven; rest physical
// - Cleared drive enable keeps pin inactive
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module ipr_router (
  input  wire logic                      ref_clk_in,
  input  wire logic                      reset_in,
  input  wire logic                      wb_cyc_in,
  input  wire logic                      wb_stb_in,
  input  wire logic                      wb_we_in,
  input  wire logic [ipr_pkg::ADR_W-1:0] wb_adr_in,
  input  wire logic [ipr_pkg::SEL_W-1:0] wb_sel_in,
  input  wire logic [ipr_pkg::DAT_W-1:0] wb_dat_in,
  output logic      [ipr_pkg::DAT_W-1:0] wb_dat_out,
  output logic                           wb_ack_out,
  input  wire logic [ipr_pkg::REG_W-1:0] phys_src_in,
  input  wire logic [ipr_pkg::NIB_W-1:0] data_src_in,
  input  wire logic                      ext_src_in,
  output logic                           irq_pin_a_out,
  output logic                           irq_pin_a_oe_out,
  output logic                           irq_pin_b_out,
  output logic                           irq_pin_b_oe_out,
  output logic                           irq_out
);
  import ipr_pkg::*;

  logic [REG_W-1:0] pin_a_phys_route_reg;
  logic [REG_W-1:0] data_driven_route_reg;
  logic [REG_W-1:0] pin_b_phys_route_reg;
  logic [REG_W-1:0] out_ctrl_reg;
  logic [1:0]       ext_route_reg;
  logic [ST_W-1:0]  int_status_reg;
  logic [ST_W-1:0]  int_status_next;
  logic [ST_W-1:0]  int_mask_reg;
  logic [DAT_W-1:0] dat_reg;
  logic [DAT_W-1:0] rd_mux;
  logic             ack_reg;
  logic             ext_meta_reg;
  logic             ext_sync_reg;

  wire [7:0]       idx;
  wire             req;
  wire             wr_en;
  wire             hit_out_ctrl;
  wire             hit_pin_a;
  wire             hit_data;
  wire             hit_pin_b;
  wire             hit_ext;
  wire             hit_status;
  wire             hit_mask;
  wire             hit_level;
  wire             ext_eff_a;
  wire             ext_eff_b;
  wire             drive_a;
  wire             drive_b;
  wire             a_phys_hit;
  wire             a_data_hit;
  wire             b_phys_hit;
  wire             b_data_hit;
  wire [ST_W-1:0]  events;
  wire [ST_W-1:0]  w1c;

  // Bus decode
  assign idx          = wb_adr_in[IDX_HI:IDX_LO];
  assign req          = wb_cyc_in & wb_stb_in & ~ack_reg;
  assign wr_en        = req & wb_we_in & wb_sel_in[0];
  assign hit_out_ctrl = (idx == IDX_OUT_CTRL);
  assign hit_pin_a    = (idx == IDX_PIN_A_PHYS);
  assign hit_data     = (idx == IDX_DATA_ROUTE);
  assign hit_pin_b    = (idx == IDX_PIN_B_PHYS);
  assign hit_ext      = (idx == IDX_EXT_ROUTE);
  assign hit_status   = (idx == IDX_INT_STATUS);
  assign hit_mask     = (idx == IDX_INT_MASK);
  assign hit_level    = (idx == IDX_SRC_LEVEL);

  // External source may drive only one pin; pin A takes precedence
  assign ext_eff_a = ext_route_reg[EXT_A_BIT];
  assign ext_eff_b = ext_route_reg[EXT_B_BIT] & ~ext_route_reg[EXT_A_BIT];

  assign drive_a = out_ctrl_reg[OE_A_BIT];
  assign drive_b = out_ctrl_reg[OE_B_BIT];

  // Read mux; unmapped indices read zero and still ack
  always_comb begin
    rd_mux = DAT_ZERO;
    if (hit_out_ctrl) begin
      rd_mux[REG_W-1:0] = out_ctrl_reg;
    end else if (hit_pin_a) begin
      rd_mux[REG_W-1:0] = pin_a_phys_route_reg;
    end else if (hit_data) begin
      rd_mux[REG_W-1:0] = data_driven_route_reg;
    end else if (hit_pin_b) begin
      rd_mux[REG_W-1:0] = pin_b_phys_route_reg;
    end else if (hit_ext) begin
      rd_mux[1:0] = ext_route_reg;
    end else if (hit_status) begin
      rd_mux[ST_W-1:0] = int_status_reg;
    end else if (hit_mask) begin
      rd_mux[ST_W-1:0] = int_mask_reg;
    end else if (hit_level) begin
      rd_mux[REG_W-1:0] = {irq_pin_b_out, irq_pin_a_out, 2'h0, int_status_reg};
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ack_reg <= 1'b0;
      dat_reg <= DAT_ZERO;
    end else begin
      ack_reg <= req;
      dat_reg <= (req & ~wb_we_in) ? rd_mux : dat_reg;
    end
  end

  // Routing bytes, drive enables, external route and interrupt mask
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pin_a_phys_route_reg  <= ROUTE_RESET;
      data_driven_route_reg <= ROUTE_RESET;
      pin_b_phys_route_reg  <= ROUTE_RESET;
      out_ctrl_reg          <= OUT_CTRL_RESET;
      ext_route_reg         <= EXT_RESET;
      int_mask_reg          <= ST_RESET;
    end else begin
      if (wr_en && hit_pin_a) begin
        pin_a_phys_route_reg <= wb_dat_in[REG_W-1:0];
      end
      if (wr_en && hit_data) begin
        data_driven_route_reg <= wb_dat_in[REG_W-1:0];
      end
      if (wr_en && hit_pin_b) begin
        pin_b_phys_route_reg <= wb_dat_in[REG_W-1:0];
      end
      if (wr_en && hit_out_ctrl) begin
        out_ctrl_reg <= wb_dat_in[REG_W-1:0] & OUT_CTRL_MASK;
      end
      if (wr_en && hit_ext) begin
        ext_route_reg <= wb_dat_in[1:0];
      end
      if (wr_en && hit_mask) begin
        int_mask_reg <= wb_dat_in[ST_W-1:0];
      end
    end
  end

  // External source comes from a pin; two stages before use
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
    end else begin
      ext_meta_reg <= ext_src_in;
      ext_sync_reg <= ext_meta_reg;
    end
  end

  ipr_pin_merge u_pin_a (
    .ref_clk_in      (ref_clk_in),
    .reset_in        (reset_in),
    .phys_src_in     (phys_src_in),
    .phys_route_in   (pin_a_phys_route_reg),
    .data_src_in     (data_src_in),
    .data_route_in   (data_driven_route_reg[DATA_A_HI:DATA_A_LO]),
    .ext_src_in      (ext_sync_reg),
    .ext_route_in    (ext_eff_a),
    .drive_enable_in (drive_a),
    .pin_out         (irq_pin_a_out),
    .phys_hit_out    (a_phys_hit),
    .data_hit_out    (a_data_hit)
  );

  ipr_pin_merge u_pin_b (
    .ref_clk_in      (ref_clk_in),
    .reset_in        (reset_in),
    .phys_src_in     (phys_src_in),
    .phys_route_in   (pin_b_phys_route_reg),
    .data_src_in     (data_src_in),
    .data_route_in   (data_driven_route_reg[DATA_B_HI:DATA_B_LO]),
    .ext_src_in      (ext_sync_reg),
    .ext_route_in    (ext_eff_b),
    .drive_enable_in (drive_b),
    .pin_out         (irq_pin_b_out),
    .phys_hit_out    (b_phys_hit),
    .data_hit_out    (b_data_hit)
  );

  // Sticky status per pin and class; a set beats a same-cycle clear
  assign events = {b_data_hit, b_phys_hit, a_data_hit, a_phys_hit};
  assign w1c    = (wr_en && hit_status) ? wb_dat_in[ST_W-1:0] : ST_RESET;
  assign int_status_next = (int_status_reg & ~w1c) | events;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      int_status_reg <= ST_RESET;
    end else begin
      int_status_reg <= int_status_next;
    end
  end

  assign irq_out          = |(int_status_reg & int_mask_reg);
  assign irq_pin_a_oe_out = drive_a;
  assign irq_pin_b_oe_out = drive_b;
  assign wb_ack_out       = ack_reg;
  assign wb_dat_out       = dat_reg;

  a_pin_a_flat: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (phys_src_in[FLAT_BIT] && pin_a_phys_route_reg[FLAT_BIT] && drive_a) |=> irq_pin_a_out)
    else $error("flat routed to pin A did not assert it");

  a_pin_a_ready: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (data_src_in[DRDY_BIT] && data_driven_route_reg[DATA_A_HI] && drive_a) |=> irq_pin_a_out)
    else $error("data ready routed to pin A did not assert it");

  a_pin_b_ready: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (data_src_in[DRDY_BIT] && data_driven_route_reg[DATA_B_HI] && drive_b) |=> irq_pin_b_out)
    else $error("data ready routed to pin B did not assert it");

  a_pin_b_flat: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (phys_src_in[FLAT_BIT] && pin_b_phys_route_reg[FLAT_BIT] && drive_b) |=> irq_pin_b_out)
    else $error("flat routed to pin B did not assert it");

  a_route_off: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (pin_a_phys_route_reg == ROUTE_RESET && data_driven_route_reg[DATA_A_HI:DATA_A_LO] == 4'h0
     && !ext_eff_a) |=> !irq_pin_a_out)
    else $error("pin A asserted with no route set");

  a_route_reset: assert property (
    @(posedge ref_clk_in)
    $fell(reset_in) |-> (pin_a_phys_route_reg == ROUTE_RESET
      && data_driven_route_reg == ROUTE_RESET && pin_b_phys_route_reg == ROUTE_RESET))
    else $error("routing bytes not cleared by reset");

  a_ext_single: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    ext_route_reg[EXT_A_BIT] |-> !ext_eff_b)
    else $error("external source routed to both pins");

  a_power_class: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (data_src_in[PWR_BIT] && data_driven_route_reg[DATA_A_LO]) |=> ##1 int_status_reg[ST_A_PHYS])
    else $error("power-unit trigger not classed physical");

  a_drive_off: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    !drive_a |=> !irq_pin_a_out)
    else $error("pin A asserted while its drive is off");

  a_pin_or: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    $rose(irq_pin_a_out) |-> $past(any_hit(phys_src_in, pin_a_phys_route_reg)
      || |(data_src_in & data_driven_route_reg[DATA_A_HI:DATA_A_LO])
      || (ext_sync_reg && ext_eff_a)))
    else $error("pin A asserted with no routed source active");

  a_pin_b_or: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    $rose(irq_pin_b_out) |-> $past(any_hit(phys_src_in, pin_b_phys_route_reg)
      || |(data_src_in & data_driven_route_reg[DATA_B_HI:DATA_B_LO])
      || (ext_sync_reg && ext_eff_b)))
    else $error("pin B asserted with no routed source active");

  a_route_off_b: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (pin_b_phys_route_reg == ROUTE_RESET && data_driven_route_reg[DATA_B_HI:DATA_B_LO] == 4'h0
     && !ext_eff_b) |=> !irq_pin_b_out)
    else $error("pin B asserted with no route set");

  a_drive_off_b: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    !drive_b |=> !irq_pin_b_out)
    else $error("pin B asserted while its drive is off");

  // Watches the pin itself, not only the precedence wire
  a_ext_pin_b: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (ext_sync_reg && ext_route_reg[EXT_A_BIT] && pin_b_phys_route_reg == ROUTE_RESET
     && data_driven_route_reg[DATA_B_HI:DATA_B_LO] == 4'h0) |=> !irq_pin_b_out)
    else $error("external source reached pin B while routed to pin A");

  a_ext_pin_a: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (ext_sync_reg && ext_route_reg[EXT_A_BIT] && drive_a) |=> irq_pin_a_out)
    else $error("external source routed to pin A did not assert it");

  a_ready_class: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (data_src_in[DRDY_BIT] && data_driven_route_reg[DATA_A_HI])
      |=> ##1 int_status_reg[ST_A_DATA])
    else $error("data ready not classed data-driven");
endmodule // ipr_router
`default_nettype wire

/* ipr_pkg.sv */
`default_nettype none
package ipr_pkg;
  localparam int unsigned ADR_W  = 10;
  localparam int unsigned DAT_W  = 32;
  localparam int unsigned SEL_W  = 4;
  localparam int unsigned REG_W  = 8;
  localparam int unsigned NIB_W  = 4;
  localparam int unsigned ST_W   = 4;
  localparam int unsigned IDX_LO = 2;
  localparam int unsigned IDX_HI = 9;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_OUT_CTRL   = 8'h53;
  localparam logic [7:0] IDX_PIN_A_PHYS = 8'h55;
  localparam logic [7:0] IDX_DATA_ROUTE = 8'h56;
  localparam logic [7:0] IDX_PIN_B_PHYS = 8'h57;
  localparam logic [7:0] IDX_EXT_ROUTE  = 8'h70;
  localparam logic [7:0] IDX_INT_STATUS = 8'h71;
  localparam logic [7:0] IDX_INT_MASK   = 8'h72;
  localparam logic [7:0] IDX_SRC_LEVEL  = 8'h73;

  localparam logic [7:0]  ROUTE_RESET    = 8'h00;
  localparam logic [7:0]  OUT_CTRL_RESET = 8'h00;
  localparam logic [7:0]  OUT_CTRL_MASK  = 8'h88;
  localparam logic [1:0]  EXT_RESET      = 2'h0;
  localparam logic [3:0]  ST_RESET       = 4'h0;
  localparam logic [31:0] DAT_ZERO       = 32'h0000_0000;

  // Field positions
  localparam int unsigned OE_A_BIT    = 3;
  localparam int unsigned OE_B_BIT    = 7;
  localparam int unsigned DATA_A_HI   = 7;
  localparam int unsigned DATA_A_LO   = 4;
  localparam int unsigned DATA_B_HI   = 3;
  localparam int unsigned DATA_B_LO   = 0;
  localparam int unsigned DRDY_BIT    = 3;
  localparam int unsigned PWR_BIT     = 0;
  localparam int unsigned EXT_A_BIT   = 0;
  localparam int unsigned EXT_B_BIT   = 1;
  localparam int unsigned ST_A_PHYS   = 0;
  localparam int unsigned ST_A_DATA   = 1;
  localparam int unsigned ST_B_PHYS   = 2;
  localparam int unsigned ST_B_DATA   = 3;
  localparam int unsigned FLAT_BIT    = 7;

  // Ready, watermark and full are data-driven; power-unit trigger is physical
  localparam logic [3:0] DATA_CLASS_MASK = 4'hE;

  function automatic logic any_hit(input logic [7:0] src, input logic [7:0] route);
    return |(src & route);
  endfunction
endpackage
`default_nettype wire

/* ipr_pin_merge.sv */
`timescale 1ns/1ps
`default_nettype none
module ipr_pin_merge (
  input  wire logic                      ref_clk_in,
  input  wire logic                      reset_in,
  input  wire logic [ipr_pkg::REG_W-1:0] phys_src_in,
  input  wire logic [ipr_pkg::REG_W-1:0] phys_route_in,
  input  wire logic [ipr_pkg::NIB_W-1:0] data_src_in,
  input  wire logic [ipr_pkg::NIB_W-1:0] data_route_in,
  input  wire logic                      ext_src_in,
  input  wire logic                      ext_route_in,
  input  wire logic                      drive_enable_in,
  output logic                           pin_out,
  output logic                           phys_hit_out,
  output logic                           data_hit_out
);
  import ipr_pkg::*;

  logic pin_reg;
  logic phys_hit_reg;
  logic data_hit_reg;
  wire  phys_hit;
  wire  data_hit;

  // Power-unit trigger and external source count as physical
  assign phys_hit = any_hit(phys_src_in, phys_route_in)
                  | (data_src_in[PWR_BIT] & data_route_in[PWR_BIT])
                  | (ext_src_in & ext_route_in);
  assign data_hit = |(data_src_in & data_route_in & DATA_CLASS_MASK);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pin_reg      <= 1'b0;
      phys_hit_reg <= 1'b0;
      data_hit_reg <= 1'b0;
    end else begin
      pin_reg      <= drive_enable_in & (phys_hit | data_hit);
      phys_hit_reg <= phys_hit;
      data_hit_reg <= data_hit;
    end
  end

  assign pin_out      = pin_reg;
  assign phys_hit_out = phys_hit_reg;
  assign data_hit_out = data_hit_reg;
endmodule // ipr_pin_merge
`default_nettype wire

/* ipr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ipr_host_model (
  input  wire logic ref_clk_in,
  input  wire logic pin_a_in,
  input  wire logic pin_a_oe_in,
  input  wire logic pin_b_in,
  input  wire logic pin_b_oe_in,
  output logic      line_a_out,
  output logic      line_b_out
);
  // Pull-down at the host, so a released line reads low, not its last value
  always_ff @(posedge ref_clk_in) begin
    line_a_out <= pin_a_oe_in & pin_a_in;
    line_b_out <= pin_b_oe_in & pin_b_in;
  end
endmodule // ipr_host_model
`default_nettype wire

/* ipr_router_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module ipr_router_bench;
  import ipr_pkg::*;
  logic             ref_clk_in = 1'b0;
  logic             reset_in = 1'b1;
  logic             cyc = 1'b0, stb = 1'b0, we = 1'b0, rd_pending = 1'b0, ext_src = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [DAT_W-1:0] dat = '0;
  logic [DAT_W-1:0] dat_out;
  logic [7:0]       phys_src = 8'h00;
  logic [3:0]       data_src = 4'h0;
  logic             ack, pa, pa_oe, pb, pb_oe, irq, line_a, line_b;
  int               mismatches = 0;
  int               n_checks = 0;
  string            nm_q[$];
  logic [7:0]       ex_q[$];
  event             probe;

  always #5 ref_clk_in = ~ref_clk_in;

  ipr_router dut_u (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(dat),
    .wb_dat_out(dat_out), .wb_ack_out(ack), .phys_src_in(phys_src), .data_src_in(data_src),
    .ext_src_in(ext_src), .irq_pin_a_out(pa), .irq_pin_a_oe_out(pa_oe), .irq_pin_b_out(pb),
    .irq_pin_b_oe_out(pb_oe), .irq_out(irq));

  ipr_host_model host_u (.ref_clk_in(ref_clk_in), .pin_a_in(pa), .pin_a_oe_in(pa_oe),
    .pin_b_in(pb), .pin_b_oe_in(pb_oe), .line_a_out(line_a), .line_b_out(line_b));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [7:0] seen);
    string      nm;
    logic [7:0] ex;
    nm = nm_q.pop_front();
    ex = ex_q.pop_front();
    n_checks++;
    if (seen !== ex) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  // Reads are judged at the edge where ack is sampled
  always @(posedge ref_clk_in) begin
    if (rd_pending && ack === 1'b1) begin
      cmp(dat_out[7:0]);
    end
  end

  always @(probe) begin
    cmp({1'b0, line_b, line_a, irq, pb_oe, pa_oe, pb, pa});
  end

  // Called just after a rising edge; holds the request until ack is seen
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h000000, d};
    rd_pending <= !w;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("BAD ack expected 1 seen %b", ack);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    rd_pending <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] ex, input string nm);
    nm_q.push_back(nm);
    ex_q.push_back(ex);
    bus(1'b0, idx, 8'h00);
  endtask

  // Pins are already gated by drive enable; settle covers the 3-cycle external path
  task automatic pins(input logic a, input logic b, input logic [1:0] oe, input logic i,
                      input string nm);
    nm_q.push_back(nm);
    ex_q.push_back({1'b0, b, a, i, oe, b, a});
    repeat (5) @(posedge ref_clk_in);
    #1;
    -> probe;
    @(posedge ref_clk_in);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    mismatches++;
    $display("BAD watchdog expected done seen hang");
    finish_test();
  end

  initial begin
    logic [7:0] ra, rb, rdr, v;
    v = 8'($urandom(32'h365b6be7));
    repeat (4) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    rd(IDX_PIN_A_PHYS, 8'h00, "route_a");
    rd(IDX_DATA_ROUTE, 8'h00, "route_d");
    rd(IDX_PIN_B_PHYS, 8'h00, "route_b");
    pins(1'b0, 1'b0, 2'b00, 1'b0, "pins_rst");
    for (int i = 0; i < 3; i++) begin
      v = 8'($urandom());
      bus(1'b1, IDX_PIN_A_PHYS + 8'(i), v);
      rd(IDX_PIN_A_PHYS + 8'(i), v, "route_rw");
    end
    bus(1'b1, 8'h60, 8'hFF);
    rd(8'h60, 8'h00, "unmapped");
    $display("test registers done");
    bus(1'b1, IDX_OUT_CTRL, 8'hFF);
    rd(IDX_OUT_CTRL, 8'h88, "out_ctrl");
    for (int s = 0; s < 12; s++) begin
      ra = 8'($urandom());
      rb = 8'($urandom());
      rdr = 8'($urandom());
      bus(1'b1, IDX_PIN_A_PHYS, ra);
      bus(1'b1, IDX_DATA_ROUTE, rdr);
      bus(1'b1, IDX_PIN_B_PHYS, rb);
      phys_src <= (s < 8) ? 8'h01 << s : 8'h00;
      data_src <= (s < 8) ? 4'h0 : 4'h1 << (s - 8);
      if (s < 8) begin
        pins(ra[s], rb[s], 2'b11, 1'b0, "walk_phys");
      end else begin
        pins(rdr[s - 4], rdr[s - 8], 2'b11, 1'b0, "walk_data");
      end
    end
    data_src <= 4'h0;
    bus(1'b1, IDX_PIN_A_PHYS, 8'h80);
    bus(1'b1, IDX_PIN_B_PHYS, 8'h80);
    bus(1'b1, IDX_OUT_CTRL, 8'h08);
    phys_src <= 8'h80;
    pins(1'b1, 1'b0, 2'b01, 1'b0, "en_a");
    bus(1'b1, IDX_OUT_CTRL, 8'h80);
    pins(1'b0, 1'b1, 2'b10, 1'b0, "en_b");
    phys_src <= 8'h00;
    $display("test routing done");
    bus(1'b1, IDX_PIN_A_PHYS, 8'h00);
    bus(1'b1, IDX_PIN_B_PHYS, 8'h00);
    bus(1'b1, IDX_DATA_ROUTE, 8'h80);
    bus(1'b1, IDX_OUT_CTRL, 8'h88);
    bus(1'b1, IDX_INT_STATUS, 8'h0F);
    data_src <= 4'h8;
    pins(1'b1, 1'b0, 2'b11, 1'b0, "ready_a");
    rd(IDX_INT_STATUS, 8'h02, "status_data");
    bus(1'b1, IDX_DATA_ROUTE, 8'h11);
    data_src <= 4'h1;
    pins(1'b1, 1'b1, 2'b11, 1'b0, "trig_ab");
    rd(IDX_INT_STATUS, 8'h07, "status_phys");
    rd(IDX_SRC_LEVEL, 8'hC7, "live_view");
    bus(1'b1, IDX_INT_MASK, 8'h04);
    rd(IDX_INT_MASK, 8'h04, "mask");
    pins(1'b1, 1'b1, 2'b11, 1'b1, "irq_on");
    data_src <= 4'h0;
    // Let the last hit leave the hit flops, or set-wins undoes the clear
    repeat (2) @(posedge ref_clk_in);
    bus(1'b1, IDX_INT_STATUS, 8'h07);
    pins(1'b0, 1'b0, 2'b11, 1'b0, "irq_off");
    rd(IDX_INT_STATUS, 8'h00, "status_clr");
    $display("test status done");
    // Every other route stays clear while the external source is routed
    bus(1'b1, IDX_DATA_ROUTE, 8'h00);
    bus(1'b1, IDX_EXT_ROUTE, 8'h03);
    ext_src <= 1'b1;
    pins(1'b1, 1'b0, 2'b11, 1'b0, "ext_both");
    rd(IDX_INT_STATUS, 8'h01, "ext_status");
    ext_src <= 1'b0;
    bus(1'b1, IDX_EXT_ROUTE, 8'h00);
    bus(1'b1, IDX_PIN_A_PHYS, 8'hFF);
    $display("test external done");
    reset_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    rd(IDX_PIN_A_PHYS, 8'h00, "rerst_a");
    rd(IDX_EXT_ROUTE, 8'h00, "rerst_ext");
    rd(IDX_INT_MASK, 8'h00, "rerst_mask");
    pins(1'b0, 1'b0, 2'b00, 1'b0, "rerst_pins");
    $display("test reset done");
    finish_test();
  end
endmodule // ipr_router_bench
`default_nettype wire
